// [design/dcm_map_unit.sv]
// Top: data map selection, code RAM window and register space decode
// Contract
// - With the signal core disabled, its code RAM is the supervisory data range from 0x1000.
// - Every reset leaves the signal core disabled.
// - The signal core's code memory is 4K words of 16 bits, 8 kilobytes.
// - The supervisory data map is chosen from the current instruction pointer.
// - Outside flash programming the region being fetched from is never readable as data; flash reads only from ROM.
// - During flash programming the flash array is mapped into data space.
// - Register space decodes as 16 modules of 32 registers, 512 in all.
// - Modules 7 to 15 are system registers and modules 0 to 5 peripheral registers.
// - Each core has its own system and peripheral register sets.
// - The supervisory mask and pending registers lack the module 5 bit.
// - The supervisory control register lacks the data segment and user memory bits.
// - Clock control bit 5 is loop mode, bit 6 loop select; crystal and regulator bits absent; the code keeps all of bits 0 to 7 (mask 0x00FF).
// - Entering supervisory stop disables the signal core.
// - The signal core has an idle mode that halts it until a converter sample arrives.
// - The supervisory core runs at half the signal core clock.
// - Firmware loads the code window, enables the signal core, then polls mailboxes.
//
// The plain strobed port and the register addresses were decided locally.
module dcm_map_unit #(
  parameter int CODE_WORDS = dcm_pkg::CODE_RAM_WORDS
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Supervisory instruction pointer and flash programming state
  input wire logic [15:0] sup_ip_in,
  input wire logic flash_prog_in,
  // Supervisory data bus
  input wire dcm_pkg::dcm_req_s sup_data_in,
  output logic [15:0] sup_data_rdata_out,
  output logic sup_flash_sel_out,
  output logic sup_sram_sel_out,
  output logic [15:0] flash_rdata_in_unused_out,
  input wire logic [15:0] flash_rdata_in,
  // Register space of the supervisory core
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic [3:0] sup_per_mod_out,
  output logic sup_per_sel_out,
  input wire logic [15:0] sup_per_rdata_in,
  input wire logic [4:0] sup_pending_in,
  // Signal core fetch and status
  input wire logic [11:0] sig_ip_in,
  input wire logic sample_ready_in,
  output logic [15:0] sig_fetch_data_out,
  output logic sig_run_out,
  output logic sig_halt_out,
  output logic sig_stop_req_out,
  output logic sup_clk_en_out
);
  dcm_pkg::dcm_state_s st;
  dcm_pkg::dcm_state_s next_st;
  dcm_pkg::dcm_sel_e sel;
  logic fetch_rom;
  logic in_code_win;
  logic in_flash;
  logic win_ok;
  logic ram_we;
  logic [11:0] ram_addr;
  logic [15:0] ram_rdata;
  logic [3:0] reg_mod;
  logic [4:0] reg_idx;
  logic sys_sel;
  logic per_sel;
  logic ctl_hit;
  logic rd_per_q;
  logic [15:0] sys_rdata;

  initial begin
    if (CODE_WORDS != dcm_pkg::CODE_RAM_WORDS) begin
      $error("code RAM must hold 4K words");
    end
    if (dcm_pkg::MOD_COUNT * dcm_pkg::REGS_PER_MOD != dcm_pkg::REG_SPACE) begin
      $error("register space size mismatch");
    end
  end

  // Code RAM, 4K words of 16 bits
  dcm_code_ram #(
    .WORDS(CODE_WORDS),
    .AW(dcm_pkg::CODE_RAM_AW)
  ) u_code_ram (
    .clk_sys_in(clk_sys_in),
    .we_in(ram_we),
    .addr_in(ram_addr),
    .wdata_in(sup_data_in.wdata),
    .rdata_out(ram_rdata)
  );

  // Data map choice from the execution region
  always_comb begin
    fetch_rom = (sup_ip_in >= dcm_pkg::ROM_CODE_BASE) &&
      (sup_ip_in <= dcm_pkg::ROM_CODE_LAST);
    in_code_win = (sup_data_in.addr >= dcm_pkg::CODE_RAM_BASE) &&
      (sup_data_in.addr <= dcm_pkg::CODE_RAM_LAST);
    in_flash = sup_data_in.addr >= dcm_pkg::FLASH_DATA_BASE;
    win_ok = (st.sig == dcm_pkg::DCM_SIG_OFF);
    sel = dcm_pkg::DCM_SEL_NONE;
    if (in_code_win && win_ok) begin
      sel = dcm_pkg::DCM_SEL_CODE;
    end else if (in_flash && (fetch_rom || flash_prog_in)) begin
      sel = dcm_pkg::DCM_SEL_FLASH;
    end else if (sup_data_in.addr <= dcm_pkg::SRAM_LAST) begin
      sel = dcm_pkg::DCM_SEL_SRAM;
    end
  end

  // Code RAM port: window while off, fetch port while running
  always_comb begin
    if (win_ok) begin
      ram_addr = sup_data_in.addr[11:0] - dcm_pkg::CODE_RAM_BASE[11:0];
    end else begin
      ram_addr = sig_ip_in;
    end
    ram_we = (sel == dcm_pkg::DCM_SEL_CODE) && sup_data_in.wr;
  end

  // Register space decode
  always_comb begin
    reg_mod = reg_addr_in[3:0];
    reg_idx = reg_addr_in[8:4];
    sys_sel = (reg_mod >= dcm_pkg::SYS_MOD_FIRST);
    per_sel = (reg_mod <= dcm_pkg::PER_MOD_LAST);
    ctl_hit = sys_sel && (reg_mod == dcm_pkg::SYS_MOD_CTL);
  end

  // System register read mux for this core's own set
  always_comb begin
    sys_rdata = 16'h0000;
    if (ctl_hit) begin
      case (reg_idx)
        dcm_pkg::REG_IMR: sys_rdata = st.interrupt_mask_register & dcm_pkg::IMR_MASK;
        dcm_pkg::REG_SC: sys_rdata = st.sc & dcm_pkg::SC_MASK;
        dcm_pkg::REG_IIR: sys_rdata = {11'h000, sup_pending_in} & dcm_pkg::IIR_MASK;
        dcm_pkg::REG_CLOCK_CONTROL_REGISTER: sys_rdata = st.clock_control_register & dcm_pkg::CLOCK_CONTROL_REGISTER_MASK;
        dcm_pkg::REG_CORECTL: begin
          sys_rdata = 16'h0000;
          sys_rdata[dcm_pkg::CTL_SIG_EN] = (st.sig != dcm_pkg::DCM_SIG_OFF);
          sys_rdata[dcm_pkg::CTL_SIG_IDLE] = (st.sig == dcm_pkg::DCM_SIG_IDLE);
        end
        default: sys_rdata = 16'h0000;
      endcase
    end
  end

  // Next state
  always_comb begin
    next_st = st;
    next_st.half_clk = ~st.half_clk;
    next_st.code_rd_pend = (sel == dcm_pkg::DCM_SEL_CODE) && sup_data_in.rd;
    next_st.data_rdata = dcm_pkg::UNDEF_DATA;
    if (sup_data_in.rd && (sel == dcm_pkg::DCM_SEL_FLASH)) begin
      next_st.data_rdata = flash_rdata_in;
    end
    if (ctl_hit && reg_wr_in) begin
      case (reg_idx)
        dcm_pkg::REG_IMR: next_st.interrupt_mask_register = reg_wdata_in & dcm_pkg::IMR_MASK;
        dcm_pkg::REG_SC: next_st.sc = reg_wdata_in & dcm_pkg::SC_MASK;
        dcm_pkg::REG_CLOCK_CONTROL_REGISTER: next_st.clock_control_register = reg_wdata_in & dcm_pkg::CLOCK_CONTROL_REGISTER_MASK;
        default: next_st.interrupt_mask_register = st.interrupt_mask_register;
      endcase
    end
    // Signal core run state
    case (st.sig)
      dcm_pkg::DCM_SIG_OFF: begin
        if (ctl_hit && reg_wr_in && (reg_idx == dcm_pkg::REG_CORECTL) &&
            reg_wdata_in[dcm_pkg::CTL_SIG_EN]) begin
          next_st.sig = dcm_pkg::DCM_SIG_RUN;
        end
      end
      dcm_pkg::DCM_SIG_RUN: begin
        if (ctl_hit && reg_wr_in && (reg_idx == dcm_pkg::REG_CORECTL)) begin
          if (!reg_wdata_in[dcm_pkg::CTL_SIG_EN]) begin
            next_st.sig = dcm_pkg::DCM_SIG_OFF;
          end else if (reg_wdata_in[dcm_pkg::CTL_SIG_IDLE] && !sample_ready_in) begin
            next_st.sig = dcm_pkg::DCM_SIG_IDLE;
          end
        end
      end
      dcm_pkg::DCM_SIG_IDLE: begin
        if (sample_ready_in) begin
          next_st.sig = dcm_pkg::DCM_SIG_RUN;
        end else if (ctl_hit && reg_wr_in && (reg_idx == dcm_pkg::REG_CORECTL) &&
                     !reg_wdata_in[dcm_pkg::CTL_SIG_EN]) begin
          next_st.sig = dcm_pkg::DCM_SIG_OFF;
        end
      end
      default: next_st.sig = dcm_pkg::DCM_SIG_OFF;
    endcase
    if (next_st.clock_control_register[dcm_pkg::CLOCK_CONTROL_REGISTER_STOP]) begin
      next_st.sig = dcm_pkg::DCM_SIG_OFF;
    end
    next_st.fetch_data = (st.sig == dcm_pkg::DCM_SIG_RUN) ? ram_rdata : st.fetch_data;
    next_st.rdata = sys_sel ? sys_rdata : 16'h0000;
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st.interrupt_mask_register <= dcm_pkg::IMR_RST;
      st.sc <= dcm_pkg::SC_RST;
      st.clock_control_register <= dcm_pkg::CLOCK_CONTROL_REGISTER_RST;
      st.rdata <= 16'h0000;
      st.data_rdata <= 16'h0000;
      st.code_rd_pend <= 1'b0;
      st.fetch_data <= 16'h0000;
      st.sig <= dcm_pkg::DCM_SIG_OFF;
      st.half_clk <= 1'b0;
      rd_per_q <= 1'b0;
    end else begin
      st <= next_st;
      rd_per_q <= reg_rd_in && per_sel;
    end
  end

  // Outputs
  always_comb begin
    sup_data_rdata_out = st.code_rd_pend ? ram_rdata : st.data_rdata;
    sup_flash_sel_out = (sel == dcm_pkg::DCM_SEL_FLASH);
    sup_sram_sel_out = (sel == dcm_pkg::DCM_SEL_SRAM);
    flash_rdata_in_unused_out = 16'h0000;
    sup_per_mod_out = reg_mod;
    sup_per_sel_out = per_sel && (reg_rd_in || reg_wr_in);
    reg_rdata_out = rd_per_q ? sup_per_rdata_in : st.rdata;
    sig_fetch_data_out = st.fetch_data;
    sig_run_out = (st.sig == dcm_pkg::DCM_SIG_RUN);
    sig_halt_out = (st.sig != dcm_pkg::DCM_SIG_RUN);
    sig_stop_req_out = st.clock_control_register[dcm_pkg::CLOCK_CONTROL_REGISTER_STOP];
    sup_clk_en_out = st.half_clk;
  end
endmodule

// [design/dcm_pkg.sv]
// Package: constants and carrier types for the dual-core memory map unit
package dcm_pkg;
  // Supervisory data map
  localparam logic [15:0] CODE_RAM_BASE = 16'h1000;
  localparam int CODE_RAM_WORDS = 4096;
  localparam int CODE_RAM_AW = 12;
  localparam logic [15:0] CODE_RAM_LAST = 16'h1FFF;
  localparam logic [15:0] FLASH_DATA_BASE = 16'h8000;
  localparam logic [15:0] FLASH_DATA_LAST = 16'hFFFF;
  localparam logic [15:0] SRAM_LAST = 16'h03FF;
  // Instruction pointer regions
  localparam logic [15:0] ROM_CODE_BASE = 16'h8000;
  localparam logic [15:0] ROM_CODE_LAST = 16'h87FF;
  // Register space layout
  localparam int MOD_COUNT = 16;
  localparam int REGS_PER_MOD = 32;
  localparam int REG_SPACE = 512;
  localparam logic [3:0] SYS_MOD_FIRST = 4'h7;
  localparam logic [3:0] SYS_MOD_LAST = 4'hF;
  localparam logic [3:0] PER_MOD_LAST = 4'h5;
  // System register slots within the system module
  localparam logic [4:0] REG_IMR = 5'h00;
  localparam logic [4:0] REG_SC = 5'h01;
  localparam logic [4:0] REG_IIR = 5'h02;
  localparam logic [4:0] REG_CLOCK_CONTROL_REGISTER = 5'h03;
  localparam logic [4:0] REG_CORECTL = 5'h04;
  localparam logic [3:0] SYS_MOD_CTL = 4'h8;
  // Implemented bit masks
  localparam logic [15:0] IMR_MASK = 16'h801F;
  localparam logic [15:0] IIR_MASK = 16'h001F;
  localparam logic [15:0] SC_MASK = 16'h00E2;
  localparam logic [15:0] CLOCK_CONTROL_REGISTER_MASK = 16'h00FF;
  localparam int CLOCK_CONTROL_REGISTER_LOOP_MODE = 5;
  localparam int CLOCK_CONTROL_REGISTER_LOOP_SEL = 6;
  localparam int CLOCK_CONTROL_REGISTER_STOP = 4;
  localparam int CTL_SIG_EN = 0;
  localparam int CTL_SIG_IDLE = 1;
  // Reset values, then the value read from an unselected data address
  localparam logic [15:0] IMR_RST = 16'h0000;
  localparam logic [15:0] SC_RST = 16'h0000;
  localparam logic [15:0] CLOCK_CONTROL_REGISTER_RST = 16'h0000;
  localparam logic [15:0] UNDEF_DATA = 16'hFFFF;

  typedef enum logic [3:0] {
    DCM_SEL_NONE = 4'h1,
    DCM_SEL_SRAM = 4'h2,
    DCM_SEL_CODE = 4'h4,
    DCM_SEL_FLASH = 4'h8
  } dcm_sel_e;

  typedef enum logic [2:0] {
    DCM_SIG_OFF = 3'h1,
    DCM_SIG_RUN = 3'h2,
    DCM_SIG_IDLE = 3'h4
  } dcm_sig_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dcm_req_s;

  typedef struct packed {
    logic [15:0] interrupt_mask_register;
    logic [15:0] sc;
    logic [15:0] clock_control_register;
    logic [15:0] rdata;
    logic [15:0] data_rdata;
    logic code_rd_pend;
    logic [15:0] fetch_data;
    dcm_sig_e sig;
    logic half_clk;
  } dcm_state_s;
endpackage

// [design/dcm_code_ram.sv]
// Memory: code RAM shared by the signal core and the supervisory window
module dcm_code_ram #(
  parameter int WORDS = dcm_pkg::CODE_RAM_WORDS,
  parameter int AW = dcm_pkg::CODE_RAM_AW
) (
  input wire logic clk_sys_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem [WORDS];

  initial begin
    if (WORDS != (1 << AW)) begin
      $error("code RAM depth must be two to the address width");
    end
  end

  // One port: write or registered read
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end
endmodule

// [bench/dcm_map_unit_props.sv]
// Checker: port-level properties of the memory map unit
module dcm_map_props (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [15:0] sup_ip_in,
  input wire logic flash_prog_in,
  input wire dcm_pkg::dcm_req_s sup_data_in,
  input wire logic [15:0] sup_data_rdata_out,
  input wire logic [15:0] flash_rdata_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [3:0] sup_per_mod_out,
  input wire logic sup_per_sel_out,
  input wire logic sig_run_out,
  input wire logic sig_halt_out,
  input wire logic sup_clk_en_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Decoded request conditions
  wire flash_rd = sup_data_in.rd && sup_data_in.addr >= dcm_pkg::FLASH_DATA_BASE;
  wire ip_rom = sup_ip_in >= dcm_pkg::ROM_CODE_BASE && sup_ip_in <= dcm_pkg::ROM_CODE_LAST;
  wire win_rd = sup_data_in.rd && sup_data_in.addr[15:12] == 4'h1;
  a_reset_core_off: assert property ($fell(rst_in) |-> !sig_run_out && sig_halt_out)
    else $error("signal core not off after reset");
  a_window_refused: assert property (win_rd && sig_run_out |=> sup_data_rdata_out == 16'hFFFF)
    else $error("window readable while signal core runs");
  a_flash_hidden: assert property (flash_rd && !ip_rom && !flash_prog_in |=> sup_data_rdata_out == 16'hFFFF)
    else $error("flash readable while fetching from it");
  a_flash_from_rom: assert property (flash_rd && ip_rom |=> sup_data_rdata_out == $past(flash_rdata_in))
    else $error("flash not readable from utility code");
  a_flash_prog_map: assert property (flash_rd && flash_prog_in |=> sup_data_rdata_out == $past(flash_rdata_in))
    else $error("flash not mapped while programming");
  a_per_select: assert property ((reg_rd_in || reg_wr_in) && reg_addr_in[3:0] <= 4'h5
    |-> sup_per_sel_out && sup_per_mod_out == reg_addr_in[3:0])
    else $error("peripheral module not selected");
  a_stop_kills: assert property (reg_wr_in && reg_addr_in == 16'h0038 && reg_wdata_in[4] |=> !sig_run_out)
    else $error("stop did not disable signal core");
  a_half_rate: assert property (!$past(rst_in) |-> sup_clk_en_out != $past(sup_clk_en_out))
    else $error("supervisory enable not at half rate");
  c_flash_rom: cover property (flash_rd && ip_rom);
  c_window_wr: cover property (sup_data_in.wr && sup_data_in.addr[15:12] == 4'h1);
  c_idle_wake: cover property (sig_halt_out ##1 !sig_halt_out);
endmodule
bind dcm_map_unit dcm_map_props u_props (.clk_sys_in, .rst_in, .sup_ip_in, .flash_prog_in,
  .sup_data_in, .sup_data_rdata_out, .flash_rdata_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .sup_per_mod_out, .sup_per_sel_out, .sig_run_out, .sig_halt_out, .sup_clk_en_out);

// [bench/dcm_core_model.sv]
// Partner: flash array and peripheral modules facing the supervisory core
module dcm_core_model (
  input wire logic clk_sys_in,
  input wire dcm_pkg::dcm_req_s sup_data_in,
  input wire logic [3:0] per_mod_in,
  input wire logic per_sel_in,
  output logic [15:0] flash_rdata_out,
  output logic [15:0] per_rdata_out
);
  logic [15:0] churn = 16'h0000;
  logic [3:0] mod_q = 4'h0;
  // Idle data moves every cycle so a stale value never matches
  always_ff @(posedge clk_sys_in) begin
    churn <= churn + 16'h1357;
    if (per_sel_in) begin
      mod_q <= per_mod_in;
    end
  end
  // Flash word depends on the address only while a read is up
  assign flash_rdata_out = sup_data_in.rd ? (sup_data_in.addr ^ 16'hC3C3) : churn;
  assign per_rdata_out = {12'h5A0, mod_q};
endmodule

// [bench/dcm_map_unit_tb_top.sv]
// Testbench: directed sequences through the data and register ports
module dcm_map_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [15:0] sup_ip_in = 16'h8000;
  logic flash_prog_in = 1'b0;
  dcm_pkg::dcm_req_s sup_data_in = '0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [4:0] sup_pending_in = 5'h1F;
  logic [11:0] sig_ip_in = 12'h004;
  logic sample_ready_in = 1'b0;
  logic [15:0] sup_data_rdata_out, flash_rdata_in, reg_rdata_out, sup_per_rdata_in;
  logic [15:0] sig_fetch_data_out;
  logic [3:0] sup_per_mod_out;
  logic sup_per_sel_out, sup_flash_sel_out, sup_sram_sel_out, sig_run_out, sig_halt_out;
  logic sig_stop_req_out, sup_clk_en_out;
  int error_cnt = 0;
  int checked = 0;
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
  // Clock of 100 ns period
  always #50 clk_sys_in = ~clk_sys_in;
  dcm_map_unit DUT (.clk_sys_in, .rst_in, .sup_ip_in, .flash_prog_in, .sup_data_in,
    .sup_data_rdata_out, .sup_flash_sel_out, .sup_sram_sel_out, .flash_rdata_in_unused_out(),
    .flash_rdata_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .sup_per_mod_out, .sup_per_sel_out, .sup_per_rdata_in, .sup_pending_in, .sig_ip_in,
    .sample_ready_in, .sig_fetch_data_out, .sig_run_out, .sig_halt_out, .sig_stop_req_out,
    .sup_clk_en_out);
  dcm_core_model u_model (.clk_sys_in, .sup_data_in, .per_mod_in(sup_per_mod_out),
    .per_sel_in(sup_per_sel_out), .flash_rdata_out(flash_rdata_in), .per_rdata_out(sup_per_rdata_in));
  // One-cycle data access, write or read
  task automatic dacc(input logic [15:0] a, input logic [15:0] d, input logic rd);
    @(posedge clk_sys_in);
    sup_data_in <= '{addr: a, wdata: d, wr: !rd, rd: rd};
    @(posedge clk_sys_in);
    sup_data_in <= '0;
  endtask
  task automatic dchk(input logic [15:0] a, input logic [15:0] ex);
    dacc(a, 16'h0000, 1'b1);
    #1;
    `CHK("data read", ex, sup_data_rdata_out)
  endtask
  // One-cycle register access, write or read
  task automatic racc(input logic [15:0] a, input logic [15:0] d, input logic rd);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= !rd;
    reg_rd_in <= rd;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [15:0] ex);
    racc(a, 16'h0000, 1'b1);
    `CHK("reg read", ex, reg_rdata_out)
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    `CHK("run", 1'b0, sig_run_out)
    `CHK("halt", 1'b1, sig_halt_out)
    dacc(16'h1000, 16'hA001, 1'b0);
    dacc(16'h1FFF, 16'hA002, 1'b0);
    dacc(16'h1004, 16'hBEEF, 1'b0);
    dchk(16'h1000, 16'hA001);
    dchk(16'h1FFF, 16'hA002);
    dchk(16'h8123, 16'h8123 ^ 16'hC3C3);
    @(posedge clk_sys_in);
    sup_ip_in <= 16'h9000;
    dchk(16'h8123, 16'hFFFF);
    @(posedge clk_sys_in);
    flash_prog_in <= 1'b1;
    dchk(16'h8124, 16'h8124 ^ 16'hC3C3);
    @(posedge clk_sys_in);
    flash_prog_in <= 1'b0;
    // Address decode selects are combinational on the current address
    sup_data_in <= '{addr: 16'h0200, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
    #1;
    `CHK("sram sel", 1'b1, sup_sram_sel_out)
    `CHK("flash sel", 1'b0, sup_flash_sel_out)
    @(posedge clk_sys_in);
    sup_data_in <= '0;
    racc(16'h0008, 16'hFFFF, 1'b0);
    rchk(16'h0008, dcm_pkg::IMR_MASK & 16'hFFDF);
    racc(16'h0018, 16'hFFFF, 1'b0);
    rchk(16'h0018, dcm_pkg::SC_MASK & 16'hFFF3);
    rchk(16'h0028, 16'h001F);
    racc(16'h0038, 16'h0060, 1'b0);
    rchk(16'h0038, 16'h0060);
    rchk(16'h0009, 16'h0000);
    // Peripheral select is combinational while the strobe is up
    @(posedge clk_sys_in);
    reg_addr_in <= 16'h0025;
    reg_rd_in <= 1'b1;
    #1;
    `CHK("per sel", 1'b1, sup_per_sel_out)
    `CHK("per mod", 4'h5, sup_per_mod_out)
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    `CHK("per data", 16'h5A05, reg_rdata_out)
    racc(16'h0048, 16'h0001, 1'b0);
    `CHK("run", 1'b1, sig_run_out)
    repeat (3) @(posedge clk_sys_in);
    #1;
    `CHK("fetch", 16'hBEEF, sig_fetch_data_out)
    dacc(16'h1004, 16'h0000, 1'b0);
    dchk(16'h1004, 16'hFFFF);
    racc(16'h0048, 16'h0003, 1'b0);
    `CHK("idle halt", 1'b1, sig_halt_out)
    @(posedge clk_sys_in);
    sample_ready_in <= 1'b1;
    @(posedge clk_sys_in);
    sample_ready_in <= 1'b0;
    for (int i = 0; i < 20 && sig_halt_out === 1'b1; i++) @(posedge clk_sys_in);
    #1;
    `CHK("wake", 1'b0, sig_halt_out)
    if (sig_halt_out !== 1'b0) report_and_stop();
    racc(16'h0038, 16'h0070, 1'b0);
    `CHK("stop run", 1'b0, sig_run_out)
    `CHK("stop req", 1'b1, sig_stop_req_out)
    racc(16'h0038, 16'h0060, 1'b0);
    racc(16'h0048, 16'h0000, 1'b0);
    dchk(16'h1004, 16'hBEEF);
    racc(16'h0048, 16'h0001, 1'b0);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    `CHK("rerun", 1'b0, sig_run_out)
    report_and_stop();
  end
endmodule
